// [hdl/audio_pin_defs.svh]
// pin-role constants for the audio codec port pin logic
`ifndef AUDIO_PIN_DEFS_SVH
`define AUDIO_PIN_DEFS_SVH
`define PIN_COUNT 6
`define PIN_TXD 0
`define PIN_RXD 1
`define PIN_BCK 2
`define PIN_AUX0 3
`define PIN_AUX1 4
`define PIN_AUX2 5
`define PIN_MASK_RESET 6'h00
`define BIT_OFF 1'h0
`define BIT_ON 1'h1
`endif

// [hdl/audio_pin_pkg.sv]
// types for the audio codec port pin logic
package audio_pin_pkg;
	typedef enum logic [1:0] {
		st_reset = 2'h0,
		st_run = 2'h1
	} pin_state_t;

	// one set of pin wires: input, output, output enable
	typedef struct packed {
		logic [5:0] in;
		logic [5:0] out;
		logic [5:0] oe;
	} pin_bus_t;

	// serial core side: role wires towards transmitter and receiver
	typedef struct packed {
		logic tx_data;
		logic bit_clk_out;
		logic bit_clk_oe;
		logic flag0_out;
		logic flag0_oe;
		logic flag1_out;
		logic flag1_oe;
		logic tx_fs_out;
		logic tx_fs_oe;
		logic rx_clk_out;
		logic rx_clk_oe;
		logic rx_fs_out;
		logic rx_fs_oe;
	} core_out_t;

	typedef struct packed {
		logic rx_data;
		logic bit_clk_in;
		logic flag0_in;
		logic flag1_in;
		logic fs_in;
		logic tx_fs_in;
		logic rx_clk_in;
		logic rx_fs_in;
	} core_in_t;
endpackage

// [hdl/pin_select_bit.sv]
// one pin cell: chooses between port function, gpio and hi-z
`timescale 1ns/100ps
`default_nettype none
module pin_select_bit (
	input wire logic func_sel,
	input wire logic blocked,
	input wire logic func_out,
	input wire logic func_oe,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic pin_out,
	output logic pin_oe
);
	always_comb begin
		// a blocked pin lets go entirely, its function lives elsewhere
		if (blocked) begin
			pin_out = 1'h0;
			pin_oe = 1'h0;
		end else if (func_sel) begin
			pin_out = func_out;
			pin_oe = func_oe;
		end else begin
			pin_out = gpio_out;
			pin_oe = gpio_oe;
		end
	end
endmodule // pin_select_bit
`default_nettype wire

// [hdl/aux_role_map.sv]
// maps core roles to and from the three auxiliary pins by clock mode
`timescale 1ns/100ps
`default_nettype none
module aux_role_map (
	input wire logic async_mode,
	input wire audio_pin_pkg::core_out_t core_o,
	input wire logic [2:0] aux_in,
	output logic [2:0] aux_out,
	output logic [2:0] aux_oe,
	output logic rx_clk_in,
	output logic rx_fs_in,
	output logic flag0_in,
	output logic flag1_in,
	output logic fs_in,
	output logic tx_fs_in
);
	always_comb begin
		// one mode bit swaps aux0 and aux1 together; aux2 stays tx frame sync in both modes
		if (async_mode) begin
			aux_out = {core_o.tx_fs_out, core_o.rx_fs_out, core_o.rx_clk_out};
			aux_oe = {core_o.tx_fs_oe, core_o.rx_fs_oe, core_o.rx_clk_oe};
			rx_clk_in = aux_in[0];
			rx_fs_in = aux_in[1];
			tx_fs_in = aux_in[2];
			flag0_in = 1'h0;
			flag1_in = 1'h0;
			fs_in = 1'h0;
		end else begin
			aux_out = {core_o.tx_fs_out, core_o.flag1_out, core_o.flag0_out};
			aux_oe = {core_o.tx_fs_oe, core_o.flag1_oe, core_o.flag0_oe};
			flag0_in = aux_in[0];
			flag1_in = aux_in[1];
			fs_in = aux_in[2];
			tx_fs_in = aux_in[2];
			rx_clk_in = 1'h0;
			rx_fs_in = 1'h0;
		end
	end
endmodule // aux_role_map
`default_nettype wire

// [hdl/audio_codec_port_pins.sv]
// pin-role logic of the serial audio codec port
`timescale 1ns/100ps
`default_nettype none
`include "audio_pin_defs.svh"
module audio_codec_port_pins #(
	parameter int PINS = `PIN_COUNT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cfg_valid,
	input wire logic [5:0] cfg_func_sel,
	input wire logic cfg_async_mode,
	input wire logic alt_tx_on_irq6,
	input wire logic alt_rx_on_irq7,
	input wire logic alt_bck_on_keypad_row_pin7,
	input wire logic alt_aux2_on_keypad_row_pin6,
	input wire audio_pin_pkg::core_out_t core_o,
	output audio_pin_pkg::core_in_t core_i,
	input wire logic [5:0] gpio_out,
	input wire logic [5:0] gpio_oe,
	output logic [5:0] gpio_in,
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe
);
	typedef struct packed {
		audio_pin_pkg::pin_state_t state;
		logic [5:0] func_sel;
		logic async_mode;
		logic [5:0] out;
		logic [5:0] oe;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [5:0] func_out;
	logic [5:0] func_oe;
	logic [5:0] blocked;
	logic [5:0] mux_out;
	logic [5:0] mux_oe;
	logic [2:0] aux_out;
	logic [2:0] aux_oe;
	logic rx_clk_in;
	logic rx_fs_in;
	logic flag0_in;
	logic flag1_in;
	logic fs_in;
	logic tx_fs_in;
	logic [5:0] sel_now;
	logic mode_now;

	initial begin
		if (PINS != `PIN_COUNT) begin
			$error("audio_codec_port_pins serves exactly six pins");
		end
		// each role index must land inside the pin vector
		if (`PIN_TXD >= PINS) begin
			$error("tx data pin index out of range");
		end
		if (`PIN_RXD >= PINS) begin
			$error("rx data pin index out of range");
		end
		if (`PIN_BCK >= PINS) begin
			$error("bit clock pin index out of range");
		end
		if (`PIN_AUX2 >= PINS) begin
			$error("aux pin index out of range");
		end
		// the aux role map works on three adjacent pins
		if (`PIN_AUX1 != `PIN_AUX0 + 1) begin
			$error("aux pins must be adjacent");
		end
		if (`PIN_AUX2 != `PIN_AUX1 + 1) begin
			$error("aux pins must be adjacent");
		end
		// a non-zero reset mask would drive pins before configuration
		if (`PIN_MASK_RESET != 6'h00) begin
			$error("reset pin mask must leave every pin floating");
		end
		if (`BIT_ON == `BIT_OFF) begin
			$error("on and off levels must differ");
		end
	end

	// config about to be taken steers the output mux, so the pins
	// follow it on the very edge that loads it; inputs stay on the
	// registered config so the core never sees a half-switched role
	always_comb begin
		sel_now = s_reg.func_sel;
		mode_now = s_reg.async_mode;
		if (cfg_valid) begin
			sel_now = cfg_func_sel;
			mode_now = cfg_async_mode;
		end
	end

	aux_role_map u_aux_next (
		.async_mode(mode_now),
		.core_o(core_o),
		.aux_in(pin_in[`PIN_AUX2:`PIN_AUX0]),
		.aux_out(aux_out),
		.aux_oe(aux_oe),
		.rx_clk_in(),
		.rx_fs_in(),
		.flag0_in(),
		.flag1_in(),
		.fs_in(),
		.tx_fs_in()
	);

	aux_role_map u_aux (
		.async_mode(s_reg.async_mode),
		.core_o(core_o),
		.aux_in(pin_in[`PIN_AUX2:`PIN_AUX0]),
		.aux_out(),
		.aux_oe(),
		.rx_clk_in(rx_clk_in),
		.rx_fs_in(rx_fs_in),
		.flag0_in(flag0_in),
		.flag1_in(flag1_in),
		.fs_in(fs_in),
		.tx_fs_in(tx_fs_in)
	);

	always_comb begin
		func_out[`PIN_TXD] = core_o.tx_data;
		func_oe[`PIN_TXD] = `BIT_ON;
		func_out[`PIN_RXD] = `BIT_OFF;
		func_oe[`PIN_RXD] = `BIT_OFF;
		func_out[`PIN_BCK] = core_o.bit_clk_out;
		func_oe[`PIN_BCK] = core_o.bit_clk_oe;
		func_out[`PIN_AUX2:`PIN_AUX0] = aux_out;
		func_oe[`PIN_AUX2:`PIN_AUX0] = aux_oe;
		blocked = `PIN_MASK_RESET;
		blocked[`PIN_TXD] = alt_tx_on_irq6;
		blocked[`PIN_RXD] = alt_rx_on_irq7;
		blocked[`PIN_BCK] = alt_bck_on_keypad_row_pin7;
		blocked[`PIN_AUX2] = alt_aux2_on_keypad_row_pin6;
	end

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			pin_select_bit u_bit (
				.func_sel(sel_now[g]),
				.blocked(blocked[g]),
				.func_out(func_out[g]),
				.func_oe(func_oe[g]),
				.gpio_out(gpio_out[g]),
				.gpio_oe(gpio_oe[g]),
				.pin_out(mux_out[g]),
				.pin_oe(mux_oe[g])
			);
		end
	endgenerate

	always_comb begin
		s_next = s_reg;
		// config taken only when presented; held otherwise
		if (cfg_valid) begin
			s_next.state = audio_pin_pkg::st_run;
			s_next.func_sel = cfg_func_sel;
			s_next.async_mode = cfg_async_mode;
		end
		unique case (s_next.state)
			audio_pin_pkg::st_reset: begin
				s_next.out = `PIN_MASK_RESET;
				s_next.oe = `PIN_MASK_RESET;
			end
			audio_pin_pkg::st_run: begin
				s_next.out = mux_out;
				s_next.oe = mux_oe;
			end
			default: begin
				s_next.out = `PIN_MASK_RESET;
				s_next.oe = `PIN_MASK_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_out = s_reg.out;
	assign pin_oe = s_reg.oe;

	always_comb begin
		// gpio sees pins in gpio role; blocked or function pins read zero
		gpio_in = pin_in & ~s_reg.func_sel & ~blocked;
		core_i.rx_data = s_reg.func_sel[`PIN_RXD] & ~blocked[`PIN_RXD] & pin_in[`PIN_RXD];
		core_i.bit_clk_in = s_reg.func_sel[`PIN_BCK] & ~blocked[`PIN_BCK] & pin_in[`PIN_BCK];
		core_i.flag0_in = s_reg.func_sel[`PIN_AUX0] & flag0_in;
		core_i.flag1_in = s_reg.func_sel[`PIN_AUX1] & flag1_in;
		core_i.rx_clk_in = s_reg.func_sel[`PIN_AUX0] & rx_clk_in;
		core_i.rx_fs_in = s_reg.func_sel[`PIN_AUX1] & rx_fs_in;
		core_i.fs_in = s_reg.func_sel[`PIN_AUX2] & ~blocked[`PIN_AUX2] & fs_in;
		core_i.tx_fs_in = s_reg.func_sel[`PIN_AUX2] & ~blocked[`PIN_AUX2] & tx_fs_in;
	end
endmodule // audio_codec_port_pins
`default_nettype wire

// [testbench/port_pin_asserts.sv]
// assertions on the audio codec port pin logic
`timescale 1ns/100ps
`default_nettype none
module port_pin_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic alt_tx_on_irq6,
	input wire logic alt_rx_on_irq7,
	input wire logic alt_aux2_on_keypad_row_pin6,
	input wire audio_pin_pkg::core_out_t core_o,
	input wire audio_pin_pkg::core_in_t core_i,
	input wire logic [5:0] gpio_oe,
	input wire logic [5:0] gpio_in,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_reset_hiz;
		disable iff (1'h0) rst |=> pin_oe == 6'h00;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else $error("pin driven after reset");
	property p_tx_data;
		!$past(gpio_oe[0]) && pin_oe[0] |-> pin_out[0] == $past(core_o.tx_data);
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("tx bit wrong");
	property p_bck;
		!$past(gpio_oe[2]) && pin_oe[2] |-> pin_out[2] == $past(core_o.bit_clk_out);
	endproperty
	a_bck: assert property (p_bck) else $error("bit clock wrong");
	property p_tx_block;
		alt_tx_on_irq6 |=> !pin_oe[0] && !pin_out[0];
	endproperty
	a_tx_block: assert property (p_tx_block) else $error("tx pin not let go");
	property p_aux2_block;
		alt_aux2_on_keypad_row_pin6 |=> !pin_oe[5];
	endproperty
	a_aux2_block: assert property (p_aux2_block) else $error("aux2 not let go");
	property p_rx_excl;
		pin_in[1] && !alt_rx_on_irq7 |-> gpio_in[1] != core_i.rx_data;
	endproperty
	a_rx_excl: assert property (p_rx_excl) else $error("rx pin role wrong");
	property p_mode_excl;
		core_i.flag0_in || core_i.flag1_in || core_i.fs_in |-> !core_i.rx_clk_in && !core_i.rx_fs_in;
	endproperty
	a_mode_excl: assert property (p_mode_excl) else $error("aux roles mixed");
	property p_fs_shared;
		core_i.fs_in |-> core_i.tx_fs_in;
	endproperty
	a_fs_shared: assert property (p_fs_shared) else $error("frame sync not shared");
endmodule // port_pin_chk
bind audio_codec_port_pins port_pin_chk chk_i (.*);
`default_nettype wire

// [testbench/codec_model.sv]
// model of the external codec and the pin pulls
`timescale 1ns/100ps
`default_nettype none
module codec_model (
	input wire logic core_clk,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] drv,
	input wire logic [5:0] drv_en,
	output logic [5:0] pin_in
);
	logic tog_reg = 1'h0;
	// aux0/aux1 have no pull: a float must not look like a held value
	always @(posedge core_clk) tog_reg <= ~tog_reg;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv)
		| (~pin_oe & ~drv_en & {1'h0, {2{tog_reg}}, 2'h0, 1'h1});
endmodule // codec_model
`default_nettype wire

// [testbench/testbench.sv]
// random bench for the audio codec port pin logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic core_clk = 1'h0;
	logic rst, cfg_valid, cfg_async_mode, alt_tx_on_irq6, alt_rx_on_irq7;
	logic alt_bck_on_keypad_row_pin7, alt_aux2_on_keypad_row_pin6, mode, on;
	logic [5:0] cfg_func_sel, gpio_out, gpio_oe, gpio_in, pin_in, pin_out, pin_oe, drv, drv_en, fs;
	logic [11:0] ex;
	logic [31:0] r;
	logic [31:0] sd = 32'h4149791f;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	audio_pin_pkg::core_out_t core_o;
	audio_pin_pkg::core_in_t core_i;
	audio_codec_port_pins uut (.*);
	codec_model partner (.*);
	always #10 core_clk = ~core_clk;
	function logic [31:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction
	function logic [5:0] blk();
		return {alt_aux2_on_keypad_row_pin6, 2'h0, alt_bck_on_keypad_row_pin7, alt_rx_on_irq7, alt_tx_on_irq6};
	endfunction
	function logic [11:0] exp_pins();
		logic [5:0] fo, fe;
		fo = {core_o.tx_fs_out, mode ? core_o.rx_fs_out : core_o.flag1_out,
			mode ? core_o.rx_clk_out : core_o.flag0_out, core_o.bit_clk_out, 2'h0};
		fo[0] = core_o.tx_data;
		fe = {core_o.tx_fs_oe, mode ? core_o.rx_fs_oe : core_o.flag1_oe,
			mode ? core_o.rx_clk_oe : core_o.flag0_oe, core_o.bit_clk_oe, 2'h1};
		return on ? {(fs & fo | ~fs & gpio_out) & ~blk(), (fs & fe | ~fs & gpio_oe) & ~blk()} : 12'h000;
	endfunction
	function logic [13:0] exp_in();
		logic [5:0] a;
		a = pin_in & fs & ~blk();
		return {a[1], a[2], a[3] & ~mode, a[4] & ~mode, a[5] & ~mode, a[5], a[3] & mode,
			a[4] & mode, pin_in & ~fs & ~blk()};
	endfunction
	task chk(input logic [13:0] seen, input logic [13:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask
	task end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 1500) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		on = 1'h0;
		for (int i = 0; i < 1200; i++) begin
			r = rnd();
			// rare resets mid-run; config forced right after the first release
			rst = i < 6 || r[7:0] == 8'h00;
			cfg_valid = i == 6 || r[9:8] == 2'h0;
			cfg_func_sel = r[15:10];
			cfg_async_mode = r[16];
			{alt_aux2_on_keypad_row_pin6, alt_bck_on_keypad_row_pin7, alt_rx_on_irq7, alt_tx_on_irq6} = r[20:17] & r[24:21];
			gpio_oe = r[30:25];
			r = rnd();
			core_o = r[12:0];
			gpio_out = r[18:13];
			drv = r[24:19];
			drv_en = r[30:25];
			#1;
			if (on)
				chk({core_i, gpio_in}, exp_in());
			if (rst) begin
				on = 1'h0;
				fs = 6'h00;
				mode = 1'h0;
			end else if (cfg_valid) begin
				on = 1'h1;
				fs = cfg_func_sel;
				mode = cfg_async_mode;
			end
			ex = exp_pins();
			@(posedge core_clk);
			#1;
			// value only compared where the pin is driven
			chk({2'h0, pin_out & pin_oe, pin_oe}, {2'h0, ex[11:6] & ex[5:0], ex[5:0]});
		end
		end_sim();
	end
endmodule // testbench
`default_nettype wire
